// File: include/rsi_pkg.sv
// constants, states and carriers for the reset init and rtc sampler block
// assumes one 125 MHz primary clock that also serves as the platform bus clock
package rsi_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLOCK_MHZ    = 125;  // primary clock rate
   localparam int MAIN_LOCK_US = 100;  // main pll lock, longest
   localparam int AUX_LOCK_US  = 50;   // local bus and peripheral bus plls
   // longest times round down; both come out exact at 125 MHz
   localparam int MAIN_LOCK_CYC = MAIN_LOCK_US * CLOCK_MHZ;
   localparam int AUX_LOCK_CYC  = AUX_LOCK_US * CLOCK_MHZ;
   localparam int CNT_W         = 14;  // holds 12500

   // ---------------------------------------------------------------
   // straps and reset values
   // ---------------------------------------------------------------
   localparam int               STRAP_W     = 8;
   localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;
   localparam logic [CNT_W-1:0]   CNT_ZERO    = 14'h0000;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   // gray along hold, capture, pll wait, run
   typedef enum logic [1:0] {
      ST_HOLD     = 2'b00,
      ST_CAPTURE  = 2'b01,
      ST_PLL_WAIT = 2'b11,
      ST_RUN      = 2'b10
   } rsi_state_type;

   typedef struct packed {
      logic               hard_reset_in_n;
      logic               soft_reset_in_n;
      logic [STRAP_W-1:0] strap;
   } rsi_pins_type;

   typedef struct packed {
      logic main_pll;
      logic lbus_pll;
      logic ppb_pll;
   } rsi_lock_type;

   localparam rsi_pins_type PINS_RESET = '{1'b0, 1'b1, STRAP_RESET};
   localparam rsi_lock_type LOCK_NONE  = '{1'b0, 1'b0, 1'b0};

   typedef struct packed {
      rsi_pins_type       meta;       // first synchroniser stage
      rsi_pins_type       pins;       // second stage, safe to use
      rsi_state_type      state;
      logic [CNT_W-1:0]   cnt;
      rsi_lock_type       lock;
      logic [STRAP_W-1:0] strap_value;
      logic               straps_valid;
      logic               core_reset_n;
      logic               soft_reset_req;
   } rsi_ctl_type;

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic tick;
   } rsi_rtc_type;

endpackage : rsi_pkg

// File: rtl/rsi_rtc_sampler.sv
// real time clock sampler: synchronises the rtc pin and emits one tick per rising edge
// assumes the pin stays high and low for more than two clock periods each
`timescale 1ns/1ps
`default_nettype none

module rsi_rtc_sampler (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clock_enable,
   // pin
   input  wire logic rtc_in,
   // synchronised result
   output logic      rtc_level,
   output logic      rtc_tick
);

   rsi_pkg::rsi_rtc_type r;
   rsi_pkg::rsi_rtc_type next_r;

   // ---------------------------------------------------------------
   // sampling
   // ---------------------------------------------------------------
   // edge taken from the second stage only; meta feeds nothing else
   always_comb begin
      next_r      = r;
      next_r.meta = rtc_in;
      next_r.sync = r.meta;
      next_r.prev = r.sync;
      // no frequency floor: a grounded pin simply never ticks
      next_r.tick = r.sync & ~r.prev;
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (clock_enable) begin
         r <= next_r;
      end
   end

   assign rtc_level = r.sync;
   assign rtc_tick  = r.tick;

endmodule : rsi_rtc_sampler

`default_nettype wire

// File: rtl/rsi_reset_init.sv
// reset initialisation sequencer with strap capture, pll lock timing and rtc sampling
// assumes a board reset controller drives the reset and strap pins asynchronously
//
// Contract
// - rtc pin is synchronised on the platform clock and drives counters and core_tick_counter
// - no lowest rtc rate; rtc tied low must be harmless
// - main plls lock within 100 us, bus plls within 50 us
// - every cycle-counted reset interval is counted on the primary clock
`timescale 1ns/1ps
`default_nettype none

module rsi_reset_init #(
   parameter int MAIN_LOCK_CYCLES = rsi_pkg::MAIN_LOCK_CYC,
   parameter int AUX_LOCK_CYCLES  = rsi_pkg::AUX_LOCK_CYC
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        clock_enable,
   // board reset, strap and rtc pins
   input  wire logic                        hard_reset_in_n,
   input  wire logic                        soft_reset_in_n,
   input  wire logic [rsi_pkg::STRAP_W-1:0] strap_in,
   input  wire logic                        rtc_in,
   // captured configuration
   output logic      [rsi_pkg::STRAP_W-1:0] strap_value,
   output logic                             straps_valid,
   // pll lock and reset release
   output logic                             main_pll_locked,
   output logic                             lbus_pll_locked,
   output logic                             ppb_pll_locked,
   output logic                             core_reset_n,
   output logic                             soft_reset_req,
   // rtc feed to interrupt_controller counters and core_tick_counter
   output logic                             rtc_level,
   output logic                             rtc_tick
);

   // ---------------------------------------------------------------
   // lock limits
   // ---------------------------------------------------------------
   localparam logic [rsi_pkg::CNT_W-1:0] MAIN_LAST = rsi_pkg::CNT_W'(MAIN_LOCK_CYCLES - 1);
   localparam logic [rsi_pkg::CNT_W-1:0] AUX_LAST  = rsi_pkg::CNT_W'(AUX_LOCK_CYCLES - 1);

   rsi_pkg::rsi_ctl_type r;
   rsi_pkg::rsi_ctl_type next_r;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   // one process for pins, state and counters; hard reset overrides all but the pin stages and strap_value
   always_comb begin
      next_r                 = r;
      next_r.meta.hard_reset_in_n = hard_reset_in_n;
      next_r.meta.soft_reset_in_n = soft_reset_in_n;
      next_r.meta.strap      = strap_in;
      next_r.pins            = r.meta;
      next_r.soft_reset_req  = 1'b0;
      if (!r.pins.hard_reset_in_n) begin
         // hold every derived output but strap_value, rtc_level and rtc_tick back while the board holds reset; strap_value keeps its last capture
         next_r.state        = rsi_pkg::ST_HOLD;
         next_r.cnt          = rsi_pkg::CNT_ZERO;
         next_r.lock         = rsi_pkg::LOCK_NONE;
         next_r.straps_valid = 1'b0;
         next_r.core_reset_n = 1'b0;
      end else begin
         case (r.state)
            rsi_pkg::ST_HOLD: begin
               // straps and reset share one pipeline delay, so setup and hold
               // seen at the pins carry over unchanged to this edge
               next_r.strap_value  = r.pins.strap;
               next_r.straps_valid = 1'b1;
               next_r.state        = rsi_pkg::ST_CAPTURE;
            end
            rsi_pkg::ST_CAPTURE: begin
               next_r.cnt   = rsi_pkg::CNT_ZERO;
               next_r.state = rsi_pkg::ST_PLL_WAIT;
            end
            rsi_pkg::ST_PLL_WAIT: begin
               // lock intervals counted in primary clock cycles
               if (r.cnt != {rsi_pkg::CNT_W{1'b1}}) begin
                  next_r.cnt = r.cnt + 1'b1;
               end
               if (r.cnt >= MAIN_LAST) begin
                  next_r.lock.main_pll = 1'b1;
               end
               if (r.cnt >= AUX_LAST) begin
                  next_r.lock.lbus_pll = 1'b1;
                  next_r.lock.ppb_pll  = 1'b1;
               end
               // release the core only once every pll reports lock
               if (next_r.lock.main_pll && next_r.lock.lbus_pll && next_r.lock.ppb_pll) begin
                  next_r.core_reset_n = 1'b1;
                  next_r.state        = rsi_pkg::ST_RUN;
               end
            end
            rsi_pkg::ST_RUN: begin
               // a level follow; the board's 3-cycle minimum keeps it clean
               next_r.soft_reset_req = ~r.pins.soft_reset_in_n;
            end
            default: begin
               next_r.state = rsi_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r.meta           <= rsi_pkg::PINS_RESET;
         r.pins           <= rsi_pkg::PINS_RESET;
         r.state          <= rsi_pkg::ST_HOLD;
         r.cnt            <= rsi_pkg::CNT_ZERO;
         r.lock           <= rsi_pkg::LOCK_NONE;
         r.strap_value    <= rsi_pkg::STRAP_RESET;
         r.straps_valid   <= 1'b0;
         r.core_reset_n   <= 1'b0;
         r.soft_reset_req <= 1'b0;
      end else if (clock_enable) begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // rtc sampling
   // ---------------------------------------------------------------
   rsi_rtc_sampler u_rtc (
      .clock        (clock),
      .rst_n        (rst_n),
      .clock_enable (clock_enable),
      .rtc_in       (rtc_in),
      .rtc_level    (rtc_level),
      .rtc_tick     (rtc_tick)
   );

   // outputs straight from flops
   assign strap_value     = r.strap_value;
   assign straps_valid    = r.straps_valid;
   assign main_pll_locked = r.lock.main_pll;
   assign lbus_pll_locked = r.lock.lbus_pll;
   assign ppb_pll_locked  = r.lock.ppb_pll;
   assign core_reset_n    = r.core_reset_n;
   assign soft_reset_req  = r.soft_reset_req;

endmodule : rsi_reset_init

`default_nettype wire

// File: testbench/rsi_props.sv
// checker on the reset sequencer ports
// assumes clock_enable is held high, rtc low and hard reset low in reset
`timescale 1ns/1ps
`default_nettype none
module rsi_props #(
   parameter int MAIN = 20,
   parameter int AUX  = 10
) (
   // clock, reset and pins
   input wire logic                        clock,
   input wire logic                        rst_n,
   input wire logic                        hard_reset_in_n,
   input wire logic                        soft_reset_in_n,
   input wire logic [rsi_pkg::STRAP_W-1:0] strap_in,
   input wire logic                        rtc_in,
   // results
   input wire logic [rsi_pkg::STRAP_W-1:0] strap_value,
   input wire logic                        straps_valid,
   input wire logic                        main_pll_locked,
   input wire logic                        lbus_pll_locked,
   input wire logic                        ppb_pll_locked,
   input wire logic                        core_reset_n,
   input wire logic                        soft_reset_req,
   input wire logic                        rtc_level,
   input wire logic                        rtc_tick
);
   logic [15:0] run_cyc;
   // cycles since capture, too long for a repetition
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) run_cyc <= 16'h0000;
      else run_cyc <= straps_valid ? run_cyc + 16'h0001 : 16'h0000;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_rtc_pulse;
      rtc_level ##1 rtc_tick ##1 !rtc_tick;
   endsequence
   // straps seen on the edge the pin rise was first sampled land in the register
   sequence s_capture;
      straps_valid && strap_value == $past(strap_in, 3);
   endsequence
   AST_RTC_RISE: assert property ($rose(rtc_in) |-> ##2 s_rtc_pulse)
      else $error("rtc edge not seen as one tick");
   AST_RTC_LOW: assert property (!rtc_in [*4] |-> !rtc_tick)
      else $error("tick without rtc edge");
   // two synchroniser stages plus the capture flop: visible three samples later
   AST_CAPTURE: assert property ($rose(hard_reset_in_n) |-> ##3 s_capture)
      else $error("straps not captured");
   AST_STRAP_HOLD: assert property (
      straps_valid && $past(straps_valid) |-> $stable(strap_value))
      else $error("captured straps moved");
   AST_AUX_LOCK: assert property (
      straps_valid |-> lbus_pll_locked == (int'(run_cyc) > AUX) && ppb_pll_locked == lbus_pll_locked)
      else $error("bus pll lock time wrong");
   AST_MAIN_LOCK: assert property (
      straps_valid |-> main_pll_locked == (int'(run_cyc) > MAIN))
      else $error("main pll lock time wrong");
   AST_CORE_REL: assert property (
      core_reset_n == (main_pll_locked && lbus_pll_locked && ppb_pll_locked))
      else $error("core release not tied to locks");
   AST_SOFT: assert property (
      $fell(soft_reset_in_n) && core_reset_n |-> ##3 soft_reset_req)
      else $error("soft reset not passed on");
endmodule : rsi_props
`default_nettype wire

// File: testbench/rsi_board.sv
// board reset controller model driving reset, straps and rtc
// assumes nothing of the caller's timing: every task waits for a rising edge first
`timescale 1ns/1ps
`default_nettype none
module rsi_board #(
   parameter int HOLD = 16 // hard reset hold, scaled down from 100 us
) (
   input  wire logic       clock,
   output logic            hard_reset_in_n,
   output logic            soft_reset_in_n,
   output logic [7:0]      strap_in,
   output logic            rtc_in
);
   initial begin
      hard_reset_in_n = 1'b0;
      soft_reset_in_n = 1'b1;
      strap_in        = 8'h00;
      rtc_in          = 1'b0;
   end
   // hard reset with straps set up, held, then pins reused
   task automatic hard_cycle(input logic [7:0] s);
      @(posedge clock);
      hard_reset_in_n <= 1'b0;
      repeat (HOLD) @(posedge clock);
      strap_in <= s;
      repeat (4) @(posedge clock);
      hard_reset_in_n <= 1'b1;
      repeat (2) @(posedge clock);
      repeat (3) @(posedge clock);
      strap_in <= ~s;
   endtask : hard_cycle
   // never shorter than the minimum assertion
   task automatic soft_pulse(input int n);
      @(posedge clock);
      soft_reset_in_n <= 1'b0;
      repeat (n < 3 ? 3 : n) @(posedge clock);
      soft_reset_in_n <= 1'b1;
   endtask : soft_pulse
   task automatic rtc_run(input int n);
      @(posedge clock);
      repeat (n) begin
         rtc_in <= 1'b1;
         repeat (3) @(posedge clock);
         rtc_in <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask : rtc_run
endmodule : rsi_board
`default_nettype wire

// File: testbench/rsi_reset_init_tb_top.sv
// top bench for the reset sequencer with board model and checker
// assumes short lock counts of 20 and 10 cycles
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_init_tb_top;
   localparam int MAIN = 20;
   typedef struct packed { logic [7:0] strap; logic [7:0] exp; } rsi_row_type;
   // first row differs from the reset value so a missed capture shows
   rsi_row_type rows [3] = '{'{8'h3c, 8'h3c}, '{8'hff, 8'hff}, '{8'ha5, 8'ha5}};
   logic clock, rst_n, hr_n, sr_n, rtc, sv, ml, ll, pl, cr_n, req, lvl, tick;
   logic [7:0] strap, sval;
   int n_mismatch = 0, checked = 0, ticks = 0, t0;
   rsi_board u_board (.clock(clock), .hard_reset_in_n(hr_n), .soft_reset_in_n(sr_n),
      .strap_in(strap), .rtc_in(rtc));
   rsi_reset_init #(.MAIN_LOCK_CYCLES(MAIN), .AUX_LOCK_CYCLES(10)) DUT (.clock(clock),
      .rst_n(rst_n), .clock_enable(1'b1), .hard_reset_in_n(hr_n), .soft_reset_in_n(sr_n),
      .strap_in(strap), .rtc_in(rtc), .strap_value(sval), .straps_valid(sv),
      .main_pll_locked(ml), .lbus_pll_locked(ll), .ppb_pll_locked(pl), .core_reset_n(cr_n),
      .soft_reset_req(req), .rtc_level(lvl), .rtc_tick(tick));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) if (tick === 1'b1) ticks <= ticks + 1;
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_sim;
      if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // watchdog, the run needs well under 1000 cycles
   initial begin
      #40000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      u_board.soft_pulse(6);
      #1 check("soft_req", 8'h00, {7'h00, req});
      foreach (rows[i]) begin
         u_board.hard_cycle(rows[i].strap);
         repeat (MAIN + 8) @(posedge clock);
         #1 check("strap_value", rows[i].exp, sval);
         check("locks", 8'h0f, {4'h0, ml, ll, pl, cr_n});
      end
      // the pulse starts one edge into the fork; request shows on its third edge
      fork
         u_board.soft_pulse(6);
         begin
            repeat (4) @(posedge clock);
            #1 check("soft_req", 8'h01, {7'h00, req});
         end
      join
      repeat (4) @(posedge clock);
      #1 check("soft_req", 8'h00, {7'h00, req});
      t0 = ticks;
      u_board.rtc_run(5);
      repeat (4) @(posedge clock);
      check("ticks", 8'h05, 8'(ticks - t0));
      t0 = ticks;
      repeat (40) @(posedge clock);
      check("ticks", 8'h00, 8'(ticks - t0));
      // second reset mid-run, straps now show the reused pattern
      rst_n <= 1'b0;
      @(posedge clock);
      #1 check("after reset", 8'h00, {sval[6:0], cr_n});
      @(posedge clock);
      rst_n <= 1'b1;
      repeat (MAIN + 10) @(posedge clock);
      #1 check("strap_value", ~rows[2].exp, sval);
      check("core_reset_n", 8'h01, {7'h00, cr_n});
      end_sim();
   end
endmodule : rsi_reset_init_tb_top
bind rsi_reset_init rsi_props #(.MAIN(MAIN_LOCK_CYCLES), .AUX(AUX_LOCK_CYCLES)) u_props (
   .clock(clock), .rst_n(rst_n), .hard_reset_in_n(hard_reset_in_n),
   .soft_reset_in_n(soft_reset_in_n), .strap_in(strap_in), .rtc_in(rtc_in),
   .strap_value(strap_value), .straps_valid(straps_valid), .main_pll_locked(main_pll_locked),
   .lbus_pll_locked(lbus_pll_locked), .ppb_pll_locked(ppb_pll_locked),
   .core_reset_n(core_reset_n), .soft_reset_req(soft_reset_req), .rtc_level(rtc_level),
   .rtc_tick(rtc_tick));
`default_nettype wire
